// File: logic/boot_dev.sv
// Device end: power-on reset, strap capture, pin duties and host port mapping.
`timescale 1ns/1ns
`include "boot_regs.svh"
module boot_dev #(
	parameter int LOAD_CYC = `LOAD_CYC
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// Pins
	boot_if.dev pins,
	// Core status and configuration
	input wire logic [47:0] gpio_fn_i,
	input wire logic [11:0] gpio_src_i,
	input wire logic status_evt_i,
	input wire logic irq_ack_i,
	input wire logic [7:0] spi_rd_data_i,
	input wire logic reg_wr_i,
	// Results
	output logic ready_o,
	output logic spi_mode_o,
	output logic [1:0] clk_rate_o,
	output logic [1:0] i2c_addr_sel_o,
	output logic in_reset_o,
	output logic [7:0] status0_o,
	output logic reg_wr_ok_o,
	output logic test_mode_o,
	output logic port_scl_o,
	output logic port_sda_o,
	output logic port_sck_o,
	output logic port_mosi_o,
	output logic port_cs_active_o,
	output logic [11:0] gpio_in_o
);
	// A load of zero cycles would stay in the load state until the counter wraps.
	if (LOAD_CYC < 1) begin : g_bad_load
		$error("LOAD_CYC must be positive");
	end
	// Each pin owns a four-bit function code in the configuration word.
	if (`GPIO_N * 4 != $bits(gpio_fn_i)) begin : g_bad_map
		$error("function map width does not match pin count");
	end
	// Internal pulls seen on pins that nobody drives.
	localparam logic [11:0] PULL = `GPIO_PULL;
	typedef struct packed {
		logic [2:0] por_sync;
		logic [2:0] test_sync;
		logic test_lvl;
		boot_pkg::dev_state_e st;
		logic [31:0] cnt;
		logic spi_mode;
		logic [1:0] rate;
		logic [5:0] asel_sync;
		logic [1:0] asel;
		logic irq;
		logic [11:0] gpio_s0;
		logic [11:0] gpio_s1;
		logic [11:0] gpio_s2;
		logic [11:0] gpio_in;
	} dev_s;
	dev_s s_q;
	dev_s s_d;
	logic [11:0] pin_lvl;
	logic por_ok;
	always_comb begin
		// R11 weak pulls
		for (int i = 0; i < `GPIO_N; i++) begin
			if (pins.gpio_host_oe[i]) pin_lvl[i] = pins.gpio_host[i];
			else if (pins.gpio_dev_oe[i]) pin_lvl[i] = pins.gpio_dev[i];
			else pin_lvl[i] = PULL[i];
		end
	end
	// R18 two late stages agree
	assign por_ok = s_q.por_sync[2] & s_q.por_sync[1];
	always_comb begin
		s_d = s_q;
		s_d.por_sync = {s_q.por_sync[1:0], pins.por_n};
		s_d.test_sync = {s_q.test_sync[1:0], pins.test_en};
		if (s_q.test_sync[2] == s_q.test_sync[1]) s_d.test_lvl = s_q.test_sync[2];
		// Pin levels come from the board, so a change only counts once the two late stages agree.
		s_d.gpio_s0 = pin_lvl;
		s_d.gpio_s1 = s_q.gpio_s0;
		s_d.gpio_s2 = s_q.gpio_s1;
		for (int i = 0; i < `GPIO_N; i++) begin
			if (s_q.gpio_s2[i] == s_q.gpio_s1[i]) s_d.gpio_in[i] = s_q.gpio_s2[i];
		end
		case (s_q.st)
			boot_pkg::ST_RESET: begin
				s_d.cnt = '0;
				// R18 latch straps once
				if (por_ok) begin
					// Straps come from the agreed levels, so a pin still settling is never caught.
					// R5 port mode strap
					s_d.spi_mode = s_q.gpio_in[`STRAP_MODE_BIT];
					// R6 clock rate strap
					s_d.rate = s_q.gpio_in[1:0];
					s_d.st = boot_pkg::ST_LOAD;
				end
			end
			boot_pkg::ST_LOAD: begin
				// R19 load before ready
				s_d.cnt = s_q.cnt + 32'h1;
				if (s_q.cnt == 32'(LOAD_CYC - 1)) s_d.st = boot_pkg::ST_RUN;
			end
			boot_pkg::ST_RUN: begin
				// R10 sticky status interrupt
				// An event in the cycle of the acknowledge wins, so no status change is lost.
				if (status_evt_i) s_d.irq = 1'b1;
				else if (irq_ack_i) s_d.irq = 1'b0;
			end
			default: s_d.st = boot_pkg::ST_RESET;
		endcase
		// R12 address selects sampled
		s_d.asel_sync = {s_q.asel_sync[3:0], pins.host_serial_out_addr_sel_hi_host,
			pins.host_select_n_addr_sel_lo};
		if (s_q.asel_sync[5:4] == s_q.asel_sync[3:2]) s_d.asel = s_q.asel_sync[5:4];
		// R1 low reset input
		if (!por_ok) begin
			s_d.st = boot_pkg::ST_RESET;
			s_d.irq = 1'b0;
		end
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end
	logic run;
	assign run = s_q.st == boot_pkg::ST_RUN;
	// R4 ready in bit 7
	assign ready_o = run;
	assign status0_o = {run, 7'h00};
	// R19 writes gated
	// A write taken during loading would be overwritten by the loaded configuration.
	assign reg_wr_ok_o = reg_wr_i & run;
	assign in_reset_o = s_q.st == boot_pkg::ST_RESET;
	assign spi_mode_o = s_q.spi_mode;
	assign clk_rate_o = s_q.rate;
	assign i2c_addr_sel_o = s_q.asel;
	assign test_mode_o = s_q.test_lvl;
	assign gpio_in_o = s_q.gpio_in;
	assign port_scl_o = !s_q.spi_mode & pins.sck_scl_host;
	assign port_sda_o = !s_q.spi_mode & pins.si_sda_host;
	assign port_sck_o = s_q.spi_mode & pins.sck_scl_host;
	// R13 command on input
	assign port_mosi_o = s_q.spi_mode & pins.si_sda_host;
	// R14 select active low
	assign port_cs_active_o = s_q.spi_mode & run & !pins.host_select_n_addr_sel_lo;
	assign pins.host_serial_out_addr_sel_hi_dev = spi_rd_data_i[7];
	// R13 read data out
	assign pins.host_serial_out_addr_sel_hi_dev_oe = port_cs_active_o;
	// R12 I2C data unused here; acknowledges belong to the port core.
	assign pins.si_sda_dev = 1'b0;
	assign pins.si_sda_dev_oe = 1'b0;
	always_comb begin
		// R9 pin duty mapping
		for (int i = 0; i < `GPIO_N; i++) begin
			pins.gpio_dev[i] = gpio_src_i[i];
			pins.gpio_dev_oe[i] = run & (gpio_fn_i[4*i +: 4] != boot_pkg::FN_GPIO) &
				(gpio_fn_i[4*i +: 4] != boot_pkg::FN_REF_SEL);
			// R10 interrupt pin
			if (gpio_fn_i[4*i +: 4] == boot_pkg::FN_IRQ) pins.gpio_dev[i] = s_q.irq;
		end
	end
	// R16 test reset asynchronous
	logic [3:0] tap_q;
	logic tdo_q;
	logic tdo_en_q;
	always_ff @(posedge pins.tck or negedge pins.trst_n) begin
		if (!pins.trst_n) begin
			tap_q <= 4'hf;
		end else begin
			case (tap_q)
				4'hf: tap_q <= pins.tms ? 4'hf : 4'hc;
				4'hc: tap_q <= pins.tms ? 4'h7 : 4'hc;
				4'h7: tap_q <= pins.tms ? 4'h4 : 4'h6;
				4'h6: tap_q <= pins.tms ? 4'h1 : 4'h2;
				4'h2: tap_q <= pins.tms ? 4'h1 : 4'h2;
				4'h1: tap_q <= pins.tms ? 4'h5 : 4'hc;
				4'h5: tap_q <= pins.tms ? 4'h7 : 4'hc;
				4'h4: tap_q <= pins.tms ? 4'hf : 4'he;
				4'he: tap_q <= pins.tms ? 4'h9 : 4'ha;
				4'ha: tap_q <= pins.tms ? 4'h9 : 4'ha;
				4'h9: tap_q <= pins.tms ? 4'hd : 4'hc;
				4'hd: tap_q <= pins.tms ? 4'h7 : 4'hc;
				default: tap_q <= 4'hf;
			endcase
		end
	end
	// Only a bypass path is kept: data shifted in on the test input returns half a clock later.
	// R15 falling edge output
	always_ff @(negedge pins.tck or negedge pins.trst_n) begin
		if (!pins.trst_n) begin
			tdo_q <= 1'b0;
			tdo_en_q <= 1'b0;
		end else begin
			tdo_q <= pins.tdi;
			tdo_en_q <= (tap_q == 4'h2) | (tap_q == 4'ha);
		end
	end
	assign pins.tdo = tdo_q;
	// R15 off unless scanning
	assign pins.tdo_oe = tdo_en_q;
endmodule : boot_dev

// File: logic/boot_host.sv
// Board and host end: drives reset, straps, waits for readiness, then hands the port to the user.
`timescale 1ns/1ns
`include "boot_regs.svh"
module boot_host #(
	parameter int POR_LOW_CYC = `POR_LOW_CYC,
	parameter int STRAP_HOLD_CYC = `STRAP_HOLD_CYC,
	parameter int ACCESS_WAIT_CYC = `ACCESS_WAIT_CYC
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// Pins
	boot_if.host pins,
	// User side
	input wire logic start_i,
	input wire logic spi_sel_i,
	input wire logic [1:0] clk_rate_i,
	input wire logic ready_seen_i,
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic cs_n_i,
	output logic access_ok_o,
	output logic busy_o,
	output logic miso_o
);
	if (POR_LOW_CYC < 1 || STRAP_HOLD_CYC < 1 || ACCESS_WAIT_CYC < STRAP_HOLD_CYC) begin : g_bad_timing
		$error("bad host timing parameters");
	end
	typedef struct packed {
		boot_pkg::host_state_e st;
		logic [31:0] cnt;
		logic [2:0] miso_sync;
		logic miso;
	} host_s;
	host_s s_q;
	host_s s_d;
	always_comb begin
		s_d = s_q;
		s_d.miso_sync = {s_q.miso_sync[1:0], pins.host_serial_out_addr_sel_hi_dev};
		// The serial out pin crosses from the device, so a level counts once two late stages agree.
		if (s_q.miso_sync[2] == s_q.miso_sync[1]) s_d.miso = s_q.miso_sync[2];
		case (s_q.st)
			boot_pkg::HS_POR: begin
				// R2 hold reset low
				s_d.cnt = s_q.cnt + 32'h1;
				if (s_q.cnt >= 32'(POR_LOW_CYC - 1) && start_i) begin
					s_d.st = boot_pkg::HS_STRAP;
					s_d.cnt = '0;
				end
			end
			boot_pkg::HS_STRAP: begin
				// R7 straps held
				s_d.cnt = s_q.cnt + 32'h1;
				if (s_q.cnt == 32'(STRAP_HOLD_CYC - 1)) s_d.st = boot_pkg::HS_WAIT;
			end
			boot_pkg::HS_WAIT: begin
				// R3 wait or ready
				s_d.cnt = s_q.cnt + 32'h1;
				if (ready_seen_i || s_q.cnt == 32'(ACCESS_WAIT_CYC - 1)) s_d.st = boot_pkg::HS_DONE;
			end
			boot_pkg::HS_DONE: begin
				if (start_i) begin
					s_d.st = boot_pkg::HS_POR;
					s_d.cnt = '0;
				end
			end
			default: s_d.st = boot_pkg::HS_POR;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end
	logic strapping;
	assign strapping = (s_q.st == boot_pkg::HS_POR) | (s_q.st == boot_pkg::HS_STRAP);
	assign pins.por_n = s_q.st != boot_pkg::HS_POR;
	// R7 R8 strap drive
	assign pins.gpio_host = {8'h00, spi_sel_i, 1'b0, clk_rate_i};
	assign pins.gpio_host_oe = strapping ? 12'h03b : 12'h000;
	// R17 test enable low
	assign pins.test_en = 1'b0;
	// R16 trst pulsed at power-up
	assign pins.trst_n = s_q.st != boot_pkg::HS_POR;
	assign pins.tck = 1'b0;
	assign pins.tms = 1'b1;
	assign pins.tdi = 1'b1;
	assign access_ok_o = s_q.st == boot_pkg::HS_DONE;
	assign busy_o = !access_ok_o;
	// R13 command on input
	assign pins.sck_scl_host = access_ok_o ? sck_i : 1'b1;
	assign pins.sck_scl_host_oe = access_ok_o;
	assign pins.si_sda_host = mosi_i;
	assign pins.si_sda_host_oe = access_ok_o;
	// R14 select low only when allowed
	assign pins.host_select_n_addr_sel_lo = access_ok_o ? cs_n_i : 1'b1;
	assign pins.host_serial_out_addr_sel_hi_host = 1'b0;
	assign pins.host_serial_out_addr_sel_hi_host_oe = 1'b0;
	assign miso_o = s_q.miso;
endmodule : boot_host

// File: logic/boot_if.sv
// Pins between the clock translator and the board or host.
`timescale 1ns/1ns
interface boot_if;
	logic por_n;
	logic [11:0] gpio_host;
	logic [11:0] gpio_host_oe;
	logic [11:0] gpio_dev;
	logic [11:0] gpio_dev_oe;
	logic sck_scl_host;
	logic sck_scl_host_oe;
	logic si_sda_host;
	logic si_sda_host_oe;
	logic si_sda_dev;
	logic si_sda_dev_oe;
	logic host_serial_out_addr_sel_hi_host;
	logic host_serial_out_addr_sel_hi_host_oe;
	logic host_serial_out_addr_sel_hi_dev;
	logic host_serial_out_addr_sel_hi_dev_oe;
	logic host_select_n_addr_sel_lo;
	logic test_en;
	logic tck;
	logic tms;
	logic tdi;
	logic trst_n;
	logic tdo;
	logic tdo_oe;
	modport dev (
		input por_n, gpio_host, gpio_host_oe, sck_scl_host, sck_scl_host_oe,
		input si_sda_host, si_sda_host_oe, host_serial_out_addr_sel_hi_host,
		input host_serial_out_addr_sel_hi_host_oe, host_select_n_addr_sel_lo,
		input test_en, tck, tms, tdi, trst_n,
		output gpio_dev, gpio_dev_oe, si_sda_dev, si_sda_dev_oe,
		output host_serial_out_addr_sel_hi_dev, host_serial_out_addr_sel_hi_dev_oe, tdo, tdo_oe
	);
	modport host (
		output por_n, gpio_host, gpio_host_oe, sck_scl_host, sck_scl_host_oe,
		output si_sda_host, si_sda_host_oe, host_serial_out_addr_sel_hi_host,
		output host_serial_out_addr_sel_hi_host_oe, host_select_n_addr_sel_lo,
		output test_en, tck, tms, tdi, trst_n,
		input gpio_dev, gpio_dev_oe, si_sda_dev, si_sda_dev_oe,
		input host_serial_out_addr_sel_hi_dev, host_serial_out_addr_sel_hi_dev_oe, tdo, tdo_oe
	);
endinterface : boot_if

// File: logic/boot_pkg.sv
// Types shared by both ends of the reset and bootstrap link.
package boot_pkg;
	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_LOAD = 2'b01,
		ST_RUN = 2'b10
	} dev_state_e;
	typedef enum logic [1:0] {
		HS_POR = 2'b00,
		HS_STRAP = 2'b01,
		HS_WAIT = 2'b10,
		HS_DONE = 2'b11
	} host_state_e;
	typedef enum logic [3:0] {
		FN_GPIO = 4'h0,
		FN_LOCK = 4'h1,
		FN_HOLDOVER = 4'h2,
		FN_REF_FAIL = 4'h3,
		FN_REF_SEL = 4'h4,
		FN_OUT_EN = 4'h5,
		FN_BANK2_EN = 4'h6,
		FN_BANK4_EN = 4'h7,
		FN_IRQ = 4'h8
	} gpio_fn_e;
endpackage : boot_pkg

// File: logic/boot_regs.svh
// Constants for the reset, bootstrap and host port setup block.
// Overview of operation
// R1: Low power-on reset input resets device.
// R2: Host holds reset low 2 ms.
// R3: Host waits 50 ms or ready flag; by default the timeout count is already passed when the wait starts.
// R4: Ready flag is bit 7, address 0x00.
// R5: Pin 3 strap selects I2C or SPI.
// R6: Pins 1 and 0 select clock rate.
// R7: Board holds straps 0,1,3 for 50 ms.
// R8: Board holds pins 4,5 low 50 ms.
// R9: Pin functions assigned from configuration.
// R10: Interrupt pin flags device status changes.
// R11: Undriven pins: 5:0 low, 11:6 high.
// R12: I2C: clock SCL, input SDA, address selects.
// R13: SPI: command in on input, data out.
// R14: SPI chip select active low.
// R15: Test output changes on falling edge, else off.
// R16: Test reset low forces Test-Logic-Reset.
// R17: Board holds test enable low.
// R18: Reset release synchronised, straps latched once.
// R19: Ready low, writes ignored while loading.
`ifndef BOOT_REGS_SVH
`define BOOT_REGS_SVH
`define CLK_MHZ 25
`define POR_LOW_US 2000
`define POR_LOW_CYC ((`POR_LOW_US * `CLK_MHZ))
`define ACCESS_WAIT_US 50000
`define ACCESS_WAIT_CYC ((`ACCESS_WAIT_US * `CLK_MHZ))
`define STRAP_HOLD_US 50000
`define STRAP_HOLD_CYC ((`STRAP_HOLD_US * `CLK_MHZ))
`define LOAD_CYC 4096
`define READY_ADDR 8'h00
`define READY_BIT 7
`define STRAP_MODE_BIT 3
`define GPIO_PULL 12'hfc0
`define GPIO_N 12
`endif

// File: sim/boot_checker.sv
// Checker of the pin-level link between the two ends.
`timescale 1ns/1ns
module boot_checker #(
	parameter int POR_LOW_CYC = 8,
	parameter int STRAP_HOLD_CYC = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Link signals
	input wire logic por_n,
	input wire logic [11:0] gpio_host,
	input wire logic [11:0] gpio_host_oe,
	input wire logic [11:0] gpio_dev_oe,
	input wire logic test_en,
	input wire logic trst_n,
	input wire logic tdo_oe,
	input wire logic host_select_n_addr_sel_lo,
	input wire logic host_serial_out_addr_sel_hi_dev_oe
);
	int lo_q;
	int hi_q;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// Cycles spent low and high, restarted on every change of the reset pin.
	always_ff @(posedge clk_i) begin
		lo_q <= (sys_rst_i || por_n) ? 0 : lo_q + 1;
		hi_q <= (sys_rst_i || !por_n) ? 0 : hi_q + 1;
	end
	property p_por_low;
		$rose(por_n) |-> lo_q >= POR_LOW_CYC - 1;
	endproperty
	a_por_low: assert property (p_por_low) else $error("reset pin released too early");
	property p_strap_hold;
		por_n && hi_q > 0 && hi_q < STRAP_HOLD_CYC - 1 |-> (gpio_host_oe & 12'h03b) == 12'h03b;
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("strap pins released early");
	property p_strap_free;
		por_n && hi_q > STRAP_HOLD_CYC + 1 |-> (gpio_host_oe & 12'h03b) == 12'h000;
	endproperty
	a_strap_free: assert property (p_strap_free) else $error("strap pins never released");
	property p_strap_low;
		gpio_host_oe[4] |-> gpio_host[5:4] == 2'h0;
	endproperty
	a_strap_low: assert property (p_strap_low) else $error("pins 4 and 5 not low");
	property p_test_off;
		!test_en;
	endproperty
	a_test_off: assert property (p_test_off) else $error("test enable driven high");
	property p_trst_por;
		!por_n |-> !trst_n;
	endproperty
	a_trst_por: assert property (p_trst_por) else $error("test reset not low in reset");
	property p_tap_off;
		!trst_n |-> !tdo_oe;
	endproperty
	a_tap_off: assert property (p_tap_off) else $error("test output driven in reset");
	property p_dev_quiet;
		!por_n [*4] |-> gpio_dev_oe == 12'h000;
	endproperty
	a_dev_quiet: assert property (p_dev_quiet) else $error("pins driven in reset");
	property p_cs_gate;
		host_select_n_addr_sel_lo && $past(host_select_n_addr_sel_lo) |-> !host_serial_out_addr_sel_hi_dev_oe;
	endproperty
	a_cs_gate: assert property (p_cs_gate) else $error("serial out driven unselected");
	c_por: cover property ($rose(por_n));
	c_strap: cover property ($fell(gpio_host_oe[3]));
	c_sout: cover property (host_serial_out_addr_sel_hi_dev_oe);
endmodule : boot_checker

// File: sim/tb_top.sv
// Bench driving both ends through reset, strap capture and port use.
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
`define WAIT(c) begin n = 0; while ((c) !== 1'b1 && n < 300) begin @(negedge clk_i); n++; end \
	if ((c) !== 1'b1) begin fails++; summarize(); end end
module tb_top;
	logic clk_i = 1'h0;
	logic sys_rst_i = 1'h1;
	logic start_i = 1'h0;
	logic spi_sel_i = 1'h0;
	logic [1:0] clk_rate_i = 2'h0;
	logic sck_i = 1'h0;
	logic mosi_i = 1'h0;
	logic cs_n_i = 1'h1;
	logic [47:0] gpio_fn_i = 48'h0;
	logic [11:0] gpio_src_i = 12'h0;
	logic [7:0] spi_rd_data_i = 8'h0;
	logic reg_wr_i = 1'h0;
	logic ce_i = 1'h1;
	logic status_evt_i = 1'h0;
	logic irq_ack_i = 1'h0;
	logic ready_seen_i = 1'h0;
	logic test_mode_o, port_sda_o;
	logic [1:0] i2c_addr_sel_o;
	logic ready_o, spi_mode_o, in_reset_o, reg_wr_ok_o, access_ok_o, busy_o, miso_o;
	logic port_scl_o, port_sck_o, port_mosi_o, port_cs_active_o;
	logic [1:0] clk_rate_o;
	logic [7:0] status0_o;
	logic [11:0] gpio_in_o;
	int fails = 0;
	int check_count = 0;
	int n;
	int i;
	int f;
	boot_if bif();
	boot_dev #(.LOAD_CYC(4)) boot_dev_inst (.clk_i, .sys_rst_i, .ce_i, .pins(bif), .gpio_fn_i,
		.gpio_src_i, .status_evt_i, .irq_ack_i, .spi_rd_data_i, .reg_wr_i, .ready_o, .spi_mode_o,
		.clk_rate_o, .i2c_addr_sel_o, .in_reset_o, .status0_o, .reg_wr_ok_o, .test_mode_o, .port_scl_o,
		.port_sda_o, .port_sck_o, .port_mosi_o, .port_cs_active_o, .gpio_in_o);
	boot_host #(.POR_LOW_CYC(8), .STRAP_HOLD_CYC(16), .ACCESS_WAIT_CYC(32)) boot_host_inst (.clk_i,
		.sys_rst_i, .ce_i, .pins(bif), .start_i, .spi_sel_i, .clk_rate_i, .ready_seen_i,
		.sck_i, .mosi_i, .cs_n_i, .access_ok_o, .busy_o, .miso_o);
	boot_checker #(.POR_LOW_CYC(8), .STRAP_HOLD_CYC(16)) boot_checker_inst (.clk_i, .sys_rst_i,
		.por_n(bif.por_n), .gpio_host(bif.gpio_host), .gpio_host_oe(bif.gpio_host_oe),
		.gpio_dev_oe(bif.gpio_dev_oe), .test_en(bif.test_en), .trst_n(bif.trst_n), .tdo_oe(bif.tdo_oe),
		.host_select_n_addr_sel_lo(bif.host_select_n_addr_sel_lo),
		.host_serial_out_addr_sel_hi_dev_oe(bif.host_serial_out_addr_sel_hi_dev_oe));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	task summarize();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize
	task tick(input int k);
		repeat (k) @(negedge clk_i);
	endtask : tick
	// Start is held until the reset pin rises, so a restart from the done state is never missed.
	task boot(input logic spi, input logic [1:0] rate);
		spi_sel_i = spi;
		clk_rate_i = rate;
		start_i = 1'h1;
		`WAIT(!bif.por_n)
		tick(4);
		`CHK(in_reset_o, 1'h1)
		`CHK(ready_o, 1'h0)
		`WAIT(bif.por_n)
		start_i = 1'h0;
		reg_wr_i = 1'h1;
		tick(2);
		`CHK(reg_wr_ok_o, 1'h0)
		`CHK(access_ok_o, 1'h0)
		tick(4);
		`CHK(gpio_in_o[5:0], {2'h0, spi, 1'h0, rate})
		`WAIT(ready_o)
		`CHK(status0_o, 8'h80)
		`CHK(reg_wr_ok_o, 1'h1)
		reg_wr_i = 1'h0;
		// SPI boots poll readiness and open early; I2C boots sit out the whole wait.
		ready_seen_i = spi;
		`WAIT(access_ok_o)
		`CHK(n < 20, spi)
		ready_seen_i = 1'h0;
		tick(5);
		`CHK(gpio_in_o, 12'hfc0)
		`CHK(test_mode_o, 1'h0)
		`CHK(spi_mode_o, spi)
		`CHK(clk_rate_o, rate)
		`CHK(busy_o, 1'h0)
	endtask : boot
	task ports(input logic spi);
		cs_n_i = 1'h0;
		sck_i = 1'h1;
		mosi_i = 1'h1;
		spi_rd_data_i = 8'h80;
		tick(5);
		`CHK(port_cs_active_o, spi)
		`CHK(i2c_addr_sel_o, 2'h0)
		if (spi) begin
			`CHK(port_sck_o, 1'h1)
			`CHK(port_mosi_o, 1'h1)
			`CHK(port_sda_o, 1'h0)
			`CHK(miso_o, 1'h1)
			spi_rd_data_i = 8'h00;
			tick(5);
			`CHK(miso_o, 1'h0)
		end else begin
			`CHK(port_scl_o, 1'h1)
			`CHK(port_sda_o, 1'h1)
			sck_i = 1'h0;
			tick(5);
			`CHK(port_scl_o, 1'h0)
		end
		cs_n_i = 1'h1;
		tick(5);
		`CHK(port_cs_active_o, 1'h0)
		`CHK(i2c_addr_sel_o, 2'h1)
	endtask : ports
	initial begin
		tick(20);
		sys_rst_i = 1'h0;
		for (i = 0; i < 4; i++) begin
			boot(~i[0], 2'(3 - i));
			ports(~i[0]);
			$display("boot %0d done", i);
		end
		// Pin 7 is pulled high, so a source of zero shows whether the device drives it.
		gpio_src_i = 12'hf7f;
		for (f = 1; f < 9; f++) begin
			gpio_fn_i[31:28] = 4'(f);
			tick(5);
			`CHK(bif.gpio_dev_oe[7], f != boot_pkg::FN_REF_SEL)
			if (f != boot_pkg::FN_IRQ) begin
				`CHK(gpio_in_o[7], f == boot_pkg::FN_REF_SEL)
			end
		end
		$display("pin duty done");
		// Pin 7 now carries the interrupt, still clear.
		`CHK(gpio_in_o[7], 1'h0)
		status_evt_i = 1'h1;
		irq_ack_i = 1'h1;
		tick(1);
		status_evt_i = 1'h0;
		irq_ack_i = 1'h0;
		tick(5);
		`CHK(gpio_in_o[7], 1'h1)
		irq_ack_i = 1'h1;
		tick(1);
		irq_ack_i = 1'h0;
		tick(5);
		`CHK(gpio_in_o[7], 1'h0)
		// With the enable low an event must leave no trace once the enable returns.
		ce_i = 1'h0;
		status_evt_i = 1'h1;
		tick(5);
		`CHK(gpio_in_o[7], 1'h0)
		status_evt_i = 1'h0;
		ce_i = 1'h1;
		tick(5);
		`CHK(gpio_in_o[7], 1'h0)
		$display("interrupt done");
		summarize();
	end
endmodule : tb_top
